// ### rtl/serial_cmd_port.sv
// Half-duplex serial command port: framing, message parse and response send
`timescale 1ns/10ps
module serial_cmd_port
	import serial_cmd_pkg::*;
#(
	parameter int unsigned RESP_DELAY = RESP_DELAY_CYC
) (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic       rxd_i,
	output logic            txd_o,
	input  wire logic       panel_setup_i,
	output logic            msg_valid_o,
	output logic            msg_is_query_o,
	output logic [6:0]      msg_len_o,
	input  wire logic [5:0] msg_rd_addr_i,
	output logic [6:0]      msg_rd_data_o,
	input  wire logic       resp_valid_i,
	input  wire logic [6:0] resp_char_i,
	input  wire logic       resp_last_i,
	output logic            resp_ready_o,
	output logic            msg_drop_o
);
	typedef enum logic [2:0] {ST_RECV, ST_HOLD, ST_WAIT, ST_SEND_BODY, ST_SEND_CR, ST_SEND_LF} port_state_e;

	port_state_e state_ff;
	logic [7:0]  ovs_cnt_ff;
	logic        ovs_tick;
	logic        rx_valid;
	logic [6:0]  rx_data;
	logic        rx_err;
	logic        rx_busy;
	logic [6:0]  rx_buf [RX_BUF_DEPTH];
	logic [6:0]  wr_ptr_ff;
	logic        bad_ff;
	logic        query_ff;
	logic        last_cr_ff;
	logic        panel_s1_ff;
	logic        panel_s2_ff;
	logic [23:0] delay_ff;
	logic        tx_busy_ff;
	logic [3:0]  tx_phase_ff;
	logic [3:0]  tx_bit_ff;
	logic [9:0]  tx_shift_ff;
	logic        tx_load;
	logic [6:0]  tx_char;
	logic        resp_last_ff;
	logic [7:0]  tx_div_ff;
	logic        tx_tick;

	// Oversample tick at 16x the line rate; 10 MHz / 153600 rounds to 65
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ovs_cnt_ff <= 8'h00;
		end else if (ovs_cnt_ff == 8'(OVS_DIV - 1)) begin
			ovs_cnt_ff <= 8'h00;
		end else begin
			ovs_cnt_ff <= ovs_cnt_ff + 8'h01;
		end
	end
	assign ovs_tick = (ovs_cnt_ff == 8'(OVS_DIV - 1));

	// Front-panel setup flag arrives from other logic domains; synchronise it
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			panel_s1_ff <= 1'b0;
			panel_s2_ff <= 1'b0;
		end else begin
			panel_s1_ff <= panel_setup_i;
			panel_s2_ff <= panel_s1_ff;
		end
	end

	// Receiver is only enabled while receiving, which keeps the port half duplex
	serial_char_rx u_rx (
		.clk_sys_i    (clk_sys_i),
		.rst_i        (rst_i),
		.ovs_tick_i   (ovs_tick),
		.enable_i     (state_ff == ST_RECV && !panel_s2_ff),
		.rxd_i        (rxd_i),
		.char_valid_o (rx_valid),
		.char_data_o  (rx_data),
		.char_err_o   (rx_err),
		.busy_o       (rx_busy)
	);

	// Message buffer; 64 slots cover the longest host transmission
	always_ff @(posedge clk_sys_i) begin
		if (rx_valid && state_ff == ST_RECV && wr_ptr_ff < 7'(RX_BUF_DEPTH)) begin
			rx_buf[wr_ptr_ff[5:0]] <= rx_data;
		end
	end
	assign msg_rd_data_o = rx_buf[msg_rd_addr_i];

	// Message assembly and error tracking until CR LF ends the transmission
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_ff  <= 7'h00;
			bad_ff     <= 1'b0;
			query_ff   <= 1'b0;
			last_cr_ff <= 1'b0;
		end else if (state_ff != ST_RECV) begin
			if (state_ff == ST_HOLD) begin
				wr_ptr_ff  <= 7'h00;
				bad_ff     <= 1'b0;
				query_ff   <= 1'b0;
				last_cr_ff <= 1'b0;
			end
		end else if (rx_valid) begin
			last_cr_ff <= (rx_data == CHAR_CR);
			if (rx_err || wr_ptr_ff >= 7'(RX_BUF_DEPTH)) begin
				bad_ff <= 1'b1;
			end else begin
				wr_ptr_ff <= wr_ptr_ff + 7'h01;
			end
			if (rx_data == CHAR_QMARK) begin
				query_ff <= 1'b1;
			end
		end
	end

	// Terminator seen: CR immediately followed by LF
	logic msg_end;
	assign msg_end = rx_valid && state_ff == ST_RECV && last_cr_ff && rx_data == CHAR_LF;

	// Message hand-off pulses; semicolon-chained strings stay in one buffer
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			msg_valid_o    <= 1'b0;
			msg_is_query_o <= 1'b0;
			msg_len_o      <= 7'h00;
			msg_drop_o     <= 1'b0;
		end else begin
			msg_valid_o <= 1'b0;
			msg_drop_o  <= 1'b0;
			if (msg_end) begin
				// A bad character anywhere discards the whole message
				msg_valid_o    <= !(bad_ff || rx_err);
				msg_drop_o     <= bad_ff || rx_err;
				msg_is_query_o <= query_ff;
				msg_len_o      <= wr_ptr_ff + 7'h01;
			end
		end
	end

	// Port sequencing; transmission happens only after a clean query
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff     <= ST_RECV;
			delay_ff     <= 24'h000000;
			resp_last_ff <= 1'b0;
		end else begin
			case (state_ff)
				ST_RECV: begin
					if (msg_end) begin
						state_ff <= ST_HOLD;
						resp_last_ff <= 1'b0;
						delay_ff <= (query_ff && !bad_ff && !rx_err && !panel_s2_ff) ? 24'h000001 : 24'h000000;
					end
				end
				ST_HOLD: begin
					state_ff <= (delay_ff != 24'h000000) ? ST_WAIT : ST_RECV;
					delay_ff <= 24'h000000;
				end
				ST_WAIT: begin
					// Let the answer settle; response latency not below the typical figure
					if (delay_ff >= 24'(RESP_DELAY - 1)) begin
						state_ff <= ST_SEND_BODY;
					end else begin
						delay_ff <= delay_ff + 24'h000001;
					end
				end
				ST_SEND_BODY: begin
					if (tx_load && resp_last_i) begin
						state_ff <= ST_SEND_CR;
					end
				end
				ST_SEND_CR: begin
					if (tx_load) begin
						state_ff <= ST_SEND_LF;
					end
				end
				ST_SEND_LF: begin
					if (tx_load) begin
						resp_last_ff <= 1'b1;
					end
					if (resp_last_ff && !tx_busy_ff) begin
						state_ff <= ST_RECV;
					end
				end
				default: state_ff <= ST_RECV;
			endcase
		end
	end

	// Character source: response body from user logic, then CR LF appended
	assign resp_ready_o = (state_ff == ST_SEND_BODY) && !tx_busy_ff;
	assign tx_load = !tx_busy_ff && !resp_last_ff && (
		(state_ff == ST_SEND_BODY && resp_valid_i) ||
		state_ff == ST_SEND_CR || state_ff == ST_SEND_LF);
	assign tx_char = (state_ff == ST_SEND_CR) ? CHAR_CR :
		(state_ff == ST_SEND_LF) ? CHAR_LF : resp_char_i;

	// Transmitter: 10 bits, 16 ticks each; never runs while receiving
	// Its own divider restarts at load, so the start bit is a full bit time, not cut by the free-running tick
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			tx_busy_ff  <= 1'b0;
			tx_div_ff   <= 8'h00;
			tx_phase_ff <= 4'h0;
			tx_bit_ff   <= 4'h0;
			tx_shift_ff <= 10'h3ff;
		end else if (tx_load) begin
			tx_busy_ff  <= 1'b1;
			tx_div_ff   <= 8'h00;
			tx_phase_ff <= 4'h0;
			tx_bit_ff   <= 4'h0;
			// Stop, odd parity, data LSB first, start
			tx_shift_ff <= {1'b1, ~(^tx_char), tx_char, 1'b0};
		end else if (tx_busy_ff) begin
			tx_div_ff <= tx_tick ? 8'h00 : tx_div_ff + 8'h01;
			if (tx_tick) begin
				tx_phase_ff <= tx_phase_ff + 4'h1;
				if (tx_phase_ff == 4'hf) begin
					tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
					tx_bit_ff   <= tx_bit_ff + 4'h1;
					if (tx_bit_ff == 4'(BITS_PER_CHAR - 1)) begin
						tx_busy_ff <= 1'b0;
					end
				end
			end
		end
	end
	assign tx_tick = (tx_div_ff == 8'(OVS_DIV - 1));

	// Line idles high; no handshake lines exist
	assign txd_o = tx_shift_ff[0];
endmodule // serial_cmd_port

// ### rtl/serial_cmd_pkg.sv
// Constants shared by the half-duplex serial command port
package serial_cmd_pkg;
	localparam int unsigned CLK_HZ        = 10000000;
	localparam int unsigned BAUD_RATE     = 9600;
	localparam int unsigned OVERSAMPLE    = 16;
	localparam int unsigned OVS_DIV       = CLK_HZ / (BAUD_RATE * OVERSAMPLE);
	localparam int unsigned BITS_PER_CHAR = 10;
	localparam int unsigned DATA_BITS     = 7;
	localparam int unsigned RX_BUF_DEPTH  = 64;
	localparam int unsigned TX_BUF_DEPTH  = 64;
	localparam logic [6:0]  CHAR_CR       = 7'h0d;
	localparam logic [6:0]  CHAR_LF       = 7'h0a;
	localparam logic [6:0]  CHAR_QMARK    = 7'h3f;
	localparam logic [6:0]  CHAR_SEMI     = 7'h3b;
	localparam logic [6:0]  CHAR_SPACE    = 7'h20;
	localparam int unsigned RESP_DELAY_MS = 10;
	localparam int unsigned RESP_DELAY_CYC = CLK_HZ / 1000 * RESP_DELAY_MS;
endpackage : serial_cmd_pkg

// ### rtl/serial_char_rx.sv
// Oversampling receiver for one 7O1 character
`timescale 1ns/10ps
module serial_char_rx
	import serial_cmd_pkg::*;
(
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic       ovs_tick_i,
	input  wire logic       enable_i,
	input  wire logic       rxd_i,
	output logic            char_valid_o,
	output logic [6:0]      char_data_o,
	output logic            char_err_o,
	output logic            busy_o
);
	logic       sync1_ff;
	logic       sync2_ff;
	logic       active_ff;
	logic [3:0] phase_ff;
	logic [3:0] bit_ff;
	logic [8:0] shift_ff;

	// Two-stage synchroniser; only sync2_ff is ever looked at
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
		end else begin
			sync1_ff <= rxd_i;
			sync2_ff <= sync1_ff;
		end
	end

	// Start detect then sample at bit centres, 8 ticks in then every 16
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			active_ff    <= 1'b0;
			phase_ff     <= 4'h0;
			bit_ff       <= 4'h0;
			shift_ff     <= 9'h000;
			char_valid_o <= 1'b0;
			char_err_o   <= 1'b0;
			char_data_o  <= 7'h00;
		end else begin
			char_valid_o <= 1'b0;
			if (!active_ff) begin
				if (enable_i && !sync2_ff) begin
					active_ff <= 1'b1;
					phase_ff  <= 4'h0;
					bit_ff    <= 4'h0;
				end
			end else if (ovs_tick_i) begin
				phase_ff <= phase_ff + 4'h1;
				if (phase_ff == 4'h7) begin
					if (bit_ff == 4'h0 && sync2_ff) begin
						active_ff <= 1'b0; // Glitch, not a real start bit
					end else if (bit_ff == 4'(BITS_PER_CHAR - 1)) begin
						active_ff    <= 1'b0;
						char_valid_o <= 1'b1;
						char_data_o  <= shift_ff[7:1]; // Start bit sits in bit 0, parity in bit 8
						// Odd parity over data plus parity, stop must be high
						char_err_o   <= ~(^shift_ff[8:1]) | ~sync2_ff;
					end else begin
						shift_ff <= {sync2_ff, shift_ff[8:1]};
						bit_ff   <= bit_ff + 4'h1;
					end
				end
			end
		end
	end

	assign busy_o = active_ff;
endmodule // serial_char_rx

// ### verification/serial_cmd_port_properties.sv
// Assertion checker for the serial command port
`timescale 1ns/10ps
module serial_cmd_port_properties
	import serial_cmd_pkg::*;
#(
	parameter int unsigned RESP_DELAY = RESP_DELAY_CYC
) (
	input wire logic       clk_sys_i,
	input wire logic       rst_i,
	input wire logic       txd_o,
	input wire logic       msg_valid_o,
	input wire logic       msg_is_query_o,
	input wire logic [6:0] msg_len_o,
	input wire logic       resp_ready_o,
	input wire logic       msg_drop_o
);
	int unsigned lo_ff;
	int unsigned age_ff;
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	// Low-run length and query age; a slipped bit leaves a run off the bit grid
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			lo_ff  <= 0;
			age_ff <= 0;
		end else begin
			lo_ff  <= txd_o ? 0 : lo_ff + 1;
			age_ff <= (msg_valid_o && msg_is_query_o) ? 1 : (resp_ready_o || age_ff == 0) ? 0 : age_ff + 1;
		end
	end
	property p_idle; $fell(rst_i) |-> (txd_o && !resp_ready_o && !msg_valid_o) [*8]; endproperty
	a_idle: assert property (p_idle) else $error("not idle after reset");
	property p_delay; $rose(resp_ready_o) && age_ff != 0 |-> age_ff >= RESP_DELAY && age_ff <= RESP_DELAY + 4; endproperty
	a_delay: assert property (p_delay) else $error("answer delay off");
	property p_bit; $rose(txd_o) |-> lo_ff != 0 && lo_ff % (OVERSAMPLE * OVS_DIV) == 0; endproperty
	a_bit: assert property (p_bit) else $error("bit time off");
	property p_duplex; !txd_o |-> !msg_valid_o && !msg_drop_o; endproperty
	a_duplex: assert property (p_duplex) else $error("rx while tx");
	property p_pulse; msg_valid_o || msg_drop_o |=> !msg_valid_o && !msg_drop_o; endproperty
	a_pulse: assert property (p_pulse) else $error("end pulse too long");
	property p_drop; msg_drop_o |=> (txd_o && !resp_ready_o) [*8]; endproperty
	a_drop: assert property (p_drop) else $error("reply after drop");
	property p_cmd; msg_valid_o && !msg_is_query_o |=> (txd_o && !resp_ready_o) [*8]; endproperty
	a_cmd: assert property (p_cmd) else $error("reply to command");
	property p_len; $changed(msg_len_o) || $changed(msg_is_query_o) |-> msg_valid_o || msg_drop_o; endproperty
	a_len: assert property (p_len) else $error("message info moved");
endmodule // serial_cmd_port_properties
bind serial_cmd_port serial_cmd_port_properties #(.RESP_DELAY(RESP_DELAY)) serial_cmd_port_properties_inst (
	.clk_sys_i(clk_sys_i), .rst_i(rst_i), .txd_o(txd_o), .msg_valid_o(msg_valid_o), .msg_is_query_o(msg_is_query_o),
	.msg_len_o(msg_len_o), .resp_ready_o(resp_ready_o), .msg_drop_o(msg_drop_o));

// ### verification/host_serial_model.sv
// Behavioural host computer on the far side of the serial line
`timescale 1ns/10ps
module host_serial_model
	import serial_cmd_pkg::*;
(
	input  wire logic clk_sys_i,
	input  wire logic txd_i,
	output logic      rxd_o
);
	localparam int BIT_CLKS = OVERSAMPLE * OVS_DIV;
	logic [6:0] rx_q[$];
	int         bad_cnt = 0;
	logic [8:0] sh;
	initial rxd_o = 1'b1;
	// One frame, LSB first at the fixed bit time; bad spoils the parity
	task automatic send_char(input logic [6:0] c, input logic bad);
		logic [9:0] fr;
		fr = {1'b1, ~^c ^ bad, c, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_sys_i);
			#1 rxd_o = fr[i];
			repeat (BIT_CLKS - 1) @(posedge clk_sys_i);
		end
	endtask
	// Hold the line low for n clocks, like a stray start bit
	task automatic pull_low(input int n);
		@(posedge clk_sys_i);
		#1 rxd_o = 1'b0;
		repeat (n) @(posedge clk_sys_i);
		#1 rxd_o = 1'b1;
	endtask
	// Always listening, no flow control, so every reply is taken through its LF
	// Samples data, parity and stop at their centres, then rearms in the stop bit
	always begin
		@(negedge txd_i);
		repeat (BIT_CLKS / 2) @(posedge clk_sys_i);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT_CLKS) @(posedge clk_sys_i);
			sh[i] = txd_i;
		end
		if (^sh[7:0] !== 1'b1 || sh[8] !== 1'b1)
			bad_cnt++;
		rx_q.push_back(sh[6:0]);
	end
endmodule // host_serial_model

// ### verification/half_duplex_serial_command_port_tb.sv
// Self-checking bench for the half-duplex serial command port
`timescale 1ns/10ps
`define CHECK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin num_errors++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module half_duplex_serial_command_port_tb;
	import serial_cmd_pkg::*;
	logic       clk_sys_i = 1'b0;
	logic       rst_i = 1'b1;
	logic       panel_setup_i = 1'b0;
	logic       resp_valid_i = 1'b0;
	logic       resp_last_i = 1'b0;
	logic [6:0] resp_char_i = 7'h00;
	logic [5:0] msg_rd_addr_i = 6'h00;
	logic       rxd, txd, msg_valid_o, msg_is_query_o, resp_ready_o, msg_drop_o;
	logic [6:0] msg_len_o, msg_rd_data_o;
	int         num_errors = 0, n_compared = 0, n_valid = 0, n_drop = 0;
	always #50 clk_sys_i = ~clk_sys_i;
	// Short answer delay keeps the run brief
	serial_cmd_port #(.RESP_DELAY(20)) serial_cmd_port_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.rxd_i(rxd), .txd_o(txd), .panel_setup_i(panel_setup_i), .msg_valid_o(msg_valid_o),
		.msg_is_query_o(msg_is_query_o), .msg_len_o(msg_len_o), .msg_rd_addr_i(msg_rd_addr_i),
		.msg_rd_data_o(msg_rd_data_o), .resp_valid_i(resp_valid_i), .resp_char_i(resp_char_i),
		.resp_last_i(resp_last_i), .resp_ready_o(resp_ready_o), .msg_drop_o(msg_drop_o));
	host_serial_model host_serial_model_inst (.clk_sys_i(clk_sys_i), .txd_i(txd), .rxd_o(rxd));
	// Count message-end pulses; they last one cycle only
	always @(posedge clk_sys_i) begin
		if (msg_valid_o === 1'b1) n_valid++;
		if (msg_drop_o === 1'b1) n_drop++;
	end
	// Whole string at once with CR LF appended; bad spoils the first character's parity
	task automatic send_msg(input string s, input logic bad);
		byte b;
		for (int i = 0; i < s.len() + 2; i++) begin
			b = (i < s.len()) ? s[i] : (i == s.len()) ? byte'(CHAR_CR) : byte'(CHAR_LF);
			host_serial_model_inst.send_char(b[6:0], bad && i == 0);
		end
		#1;
	endtask
	// Spoilt parity on the CR discards the message without reply
	task automatic t_drop();
		int v = n_valid;
		int d = n_drop;
		send_msg("", 1'b1);
		`CHECK("drop", d + 1, n_drop)
		`CHECK("valid", v, n_valid)
	endtask
	// A stray start bit during panel setup is ignored; the empty command after it is stored whole, never answered
	task automatic t_cmd();
		int v = n_valid;
		int d = n_drop;
		int quiet = 1;
		panel_setup_i = 1'b1;
		repeat (4) @(posedge clk_sys_i);
		host_serial_model_inst.pull_low(OVERSAMPLE * OVS_DIV);
		repeat (4) @(posedge clk_sys_i);
		#1 panel_setup_i = 1'b0;
		send_msg("", 1'b0);
		`CHECK("panel", d, n_drop)
		`CHECK("valid", v + 1, n_valid)
		`CHECK("query", 1'b0, msg_is_query_o)
		`CHECK("len", 7'h02, msg_len_o)
		`CHECK("buf0", CHAR_CR, msg_rd_data_o)
		msg_rd_addr_i = 6'h01;
		#1 `CHECK("buf1", CHAR_LF, msg_rd_data_o)
		// No body is offered here, so a wrong reply would wait in ST_SEND_BODY with txd still high
		for (int k = 0; k < 300; k++) begin
			@(posedge clk_sys_i);
			if (txd !== 1'b1) quiet = 0;
		end
		`CHECK("quiet", 1, quiet)
		`CHECK("reply", 0, host_serial_model_inst.rx_q.size())
	endtask
	// Query gets its body, then CR and LF, odd parity throughout
	task automatic t_query();
		int k;
		send_msg("?", 1'b0);
		`CHECK("query", 1'b1, msg_is_query_o)
		`CHECK("len", 7'h03, msg_len_o)
		for (k = 0; k < 200 && resp_ready_o !== 1'b1; k++) begin
			@(posedge clk_sys_i);
			#1;
		end
		resp_valid_i = 1'b1;
		resp_char_i = 7'h4b;
		resp_last_i = 1'b1;
		@(posedge clk_sys_i);
		#1 resp_valid_i = 1'b0;
		for (k = 0; k < 40000 && host_serial_model_inst.rx_q.size() < 3; k++)
			@(posedge clk_sys_i);
		`CHECK("nrx", 3, host_serial_model_inst.rx_q.size())
		`CHECK("body", 7'h4b, host_serial_model_inst.rx_q[0])
		`CHECK("cr", CHAR_CR, host_serial_model_inst.rx_q[1])
		`CHECK("lf", CHAR_LF, host_serial_model_inst.rx_q[2])
		`CHECK("frame", 0, host_serial_model_inst.bad_cnt)
	endtask
	task automatic stop_test();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Quiet gaps are short: the port needs none at this size, and full ones would bloat the run
	initial begin
		repeat (20) @(posedge clk_sys_i);
		#1 rst_i = 1'b0;
		repeat (4) @(posedge clk_sys_i);
		t_drop();
		t_cmd();
		t_query();
		stop_test();
	end
	// Ten characters plus the stray start bit need about 106k cycles
	initial begin
		repeat (120000) @(posedge clk_sys_i);
		num_errors++;
		stop_test();
	end
endmodule // half_duplex_serial_command_port_tb
